// ### inc/lpbm_pkg.sv
// Constants, field layout and state type of the display power and battery monitor registers
`default_nettype none
package lpbm_pkg;

    // Register addresses in the special-function register space
    localparam logic [7:0] LPBM_ADDR_PWR = 8'hA4;
    localparam logic [7:0] LPBM_ADDR_VBM = 8'hA6;
    localparam logic [7:0] LPBM_ADDR_MSCF = 8'hAC;

    // display_master_config layout
    localparam int LPBM_MSCF_SLEEP_BIT = 1;
    localparam int LPBM_MSCF_BYP_BIT = 0;
    localparam logic [5:0] LPBM_MSCF_RSVD = 6'h3F;
    localparam logic [7:0] LPBM_MSCF_RST = 8'hFE;

    // display_power_select layout
    localparam int LPBM_PWR_MODE_BIT = 3;
    localparam logic [2:0] LPBM_PWR_RSVD = 3'h1;
    localparam logic [3:0] LPBM_PWR_UNUSED = 4'h0;
    localparam logic [7:0] LPBM_PWR_RST = 8'h09;

    // battery_monitor_control layout
    localparam int LPBM_VBM_EN_BIT = 7;
    localparam int LPBM_VBM_OFS_BIT = 6;
    localparam int LPBM_VBM_THR_MSB = 4;
    localparam int LPBM_VBM_THR_LSB = 0;
    localparam int LPBM_THR_W = 5;
    localparam int LPBM_CODE_W = 6;
    localparam logic [7:0] LPBM_VBM_RST = 8'h00;

    // Read value of an unmapped address
    localparam logic [7:0] LPBM_RD_NONE = 8'h00;

    // One threshold step, same as one contrast step
    localparam int LPBM_STEP_MV = 60;

    // Timing
    localparam int LPBM_CLK_MHZ = 250;
    localparam int LPBM_SETTLE_NS = 1000;
    localparam int LPBM_SETTLE_CYC = (LPBM_SETTLE_NS * LPBM_CLK_MHZ + 999) / 1000;
    localparam int LPBM_FILTER_CYC = 8;
    localparam int LPBM_CNT_W = 9;

    typedef enum logic [1:0] {
        LPBM_MON_OFF = 2'b00,
        LPBM_MON_SETTLE = 2'b01,
        LPBM_MON_WATCH = 2'b10,
        LPBM_MON_LOW = 2'b11
    } lpbm_mon_state_t;

endpackage
`default_nettype wire

// ### hdl/lpbm_sync.sv
// Two-flop synchroniser for signals entering from outside the core clock
`default_nettype none
module lpbm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### hdl/lpbm_thresh.sv
// Monitor threshold forming and comparison against the battery level code
`default_nettype none
module lpbm_thresh
    import lpbm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic offset_link,
    input wire logic [lpbm_pkg::LPBM_THR_W-1:0] thr_field,
    input wire logic [lpbm_pkg::LPBM_THR_W-1:0] contrast_level,
    // Battery level in contrast steps
    input wire logic [lpbm_pkg::LPBM_CODE_W-1:0] vbat_code,
    // Results
    output logic [lpbm_pkg::LPBM_CODE_W-1:0] thr_code,
    output logic below
);
    logic [LPBM_CODE_W-1:0] abs_code;
    logic [LPBM_CODE_W-1:0] linked_code;
    logic [LPBM_CODE_W-1:0] thr_next;

    assign abs_code = {1'b0, thr_field};
    assign linked_code = {1'b0, contrast_level} + {1'b0, thr_field};
    assign thr_next = offset_link ? linked_code : abs_code;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_code <= '0;
            below <= 1'b0;
        end else begin
            thr_code <= thr_next;
            below <= (vbat_code < thr_next);
        end
    end
endmodule
`default_nettype wire

// ### hdl/lpbm_regs.sv
// Power, pump bypass and battery monitor registers of the segment display controller
//
// Contract
// - master config bits 7:2 read ones
// - bit 1 keeps converter running in sleep
// - bit 0 bypasses the charge pump
// - power bit 3 selects contrast mode group
// - power bits 2:0 read 001
// - power bits 7:4 read zero, ignore writes
// - monitor control bit 7 enables monitor
// - bit 6 links threshold to contrast
// - monitor control bit 5 reads zero
// - unlinked threshold uses contrast encoding
// - linked threshold is contrast plus steps
// - linked threshold rises in 60mV steps
// - report low battery below threshold
// - low battery can wake from sleep
`default_nettype none
module lpbm_regs
    import lpbm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,

    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,

    // System state, same clock
    input wire logic sleep_active,
    input wire logic wake_source_en,
    input wire logic [lpbm_pkg::LPBM_THR_W-1:0] contrast_level,

    // Battery level code from the analogue digitiser, asynchronous
    input wire logic [lpbm_pkg::LPBM_CODE_W-1:0] vbat_code,

    // Power controls
    output logic converter_run,
    output logic converter_sleep_enable,
    output logic pump_bypass,
    output logic contrast_mode_group,

    // Battery monitor
    output logic monitor_on,
    output logic [lpbm_pkg::LPBM_CODE_W-1:0] monitor_threshold,
    output logic low_battery,
    output logic wake_request
);
    import lpbm_pkg::*;

    // Reset release
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Address decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    logic wr_mscf;
    logic wr_pwr;
    logic wr_vbm;
    logic rd_mscf;
    logic rd_pwr;
    logic rd_vbm;

    assign wr_mscf = sfr_wr && hit(sfr_addr, LPBM_ADDR_MSCF);
    assign wr_pwr = sfr_wr && hit(sfr_addr, LPBM_ADDR_PWR);
    assign wr_vbm = sfr_wr && hit(sfr_addr, LPBM_ADDR_VBM);
    assign rd_mscf = hit(sfr_addr, LPBM_ADDR_MSCF);
    assign rd_pwr = hit(sfr_addr, LPBM_ADDR_PWR);
    assign rd_vbm = hit(sfr_addr, LPBM_ADDR_VBM);

    // Stored fields; reserved and unused bits have no storage
    logic sleep_en_reg;
    logic bypass_reg;
    logic mode_reg;
    logic mon_en_reg;
    logic ofs_reg;
    logic [LPBM_THR_W-1:0] thr_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_en_reg <= LPBM_MSCF_RST[LPBM_MSCF_SLEEP_BIT];
            bypass_reg <= LPBM_MSCF_RST[LPBM_MSCF_BYP_BIT];
        end else if (wr_mscf) begin
            sleep_en_reg <= sfr_wdata[LPBM_MSCF_SLEEP_BIT];
            bypass_reg <= sfr_wdata[LPBM_MSCF_BYP_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= LPBM_PWR_RST[LPBM_PWR_MODE_BIT];
        end else if (wr_pwr) begin
            mode_reg <= sfr_wdata[LPBM_PWR_MODE_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_en_reg <= LPBM_VBM_RST[LPBM_VBM_EN_BIT];
            ofs_reg <= LPBM_VBM_RST[LPBM_VBM_OFS_BIT];
            thr_reg <= LPBM_VBM_RST[LPBM_VBM_THR_MSB:LPBM_VBM_THR_LSB];
        end else if (wr_vbm) begin
            mon_en_reg <= sfr_wdata[LPBM_VBM_EN_BIT];
            ofs_reg <= sfr_wdata[LPBM_VBM_OFS_BIT];
            thr_reg <= sfr_wdata[LPBM_VBM_THR_MSB:LPBM_VBM_THR_LSB];
        end
    end

    // Read-back images
    logic [7:0] mscf_img;
    logic [7:0] pwr_img;
    logic [7:0] vbm_img;
    logic [7:0] rdata_next;

    assign mscf_img = {LPBM_MSCF_RSVD, sleep_en_reg, bypass_reg};
    assign pwr_img = {LPBM_PWR_UNUSED, mode_reg, LPBM_PWR_RSVD};
    assign vbm_img = {mon_en_reg, ofs_reg, 1'b0, thr_reg};

    assign rdata_next = rd_mscf ? mscf_img :
                        rd_pwr ? pwr_img :
                        rd_vbm ? vbm_img : LPBM_RD_NONE;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= LPBM_RD_NONE;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_next;
        end
    end

    // Power control outputs
    logic converter_run_next;

    // converter stops in sleep unless kept
    assign converter_run_next = !sleep_active || sleep_en_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_run <= 1'b1;
            converter_sleep_enable <= LPBM_MSCF_RST[LPBM_MSCF_SLEEP_BIT];
            pump_bypass <= LPBM_MSCF_RST[LPBM_MSCF_BYP_BIT];
            contrast_mode_group <= LPBM_PWR_RST[LPBM_PWR_MODE_BIT];
        end else begin
            converter_run <= converter_run_next;
            converter_sleep_enable <= sleep_en_reg;
            pump_bypass <= bypass_reg;
            contrast_mode_group <= mode_reg;
        end
    end

    // Battery level crossing; a code may tear while changing, the filter below absorbs it
    logic [LPBM_CODE_W-1:0] vbat_sync;

    lpbm_sync #(
        .W(LPBM_CODE_W)
    ) u_vbat_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(vbat_code),
        .sync_out(vbat_sync)
    );

    // Threshold forming and compare
    logic below;

    lpbm_thresh u_thresh (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .offset_link(ofs_reg),
        .thr_field(thr_reg),
        .contrast_level(contrast_level),
        .vbat_code(vbat_sync),
        .thr_code(monitor_threshold),
        .below(below)
    );

    // Monitor sequencing
    lpbm_mon_state_t state_reg;
    lpbm_mon_state_t state_next;
    logic [LPBM_CNT_W-1:0] cnt_reg;
    logic [LPBM_CNT_W-1:0] cnt_next;
    logic settle_done;
    logic filt_done;
    logic cfg_touch;

    localparam logic [LPBM_CNT_W-1:0] SETTLE_LAST = LPBM_CNT_W'(LPBM_SETTLE_CYC - 1);
    localparam logic [LPBM_CNT_W-1:0] FILTER_LAST = LPBM_CNT_W'(LPBM_FILTER_CYC - 1);

    assign settle_done = (cnt_reg == SETTLE_LAST);
    assign filt_done = (cnt_reg == FILTER_LAST);
    // Retuning disturbs the comparator, so settle again
    assign cfg_touch = wr_vbm;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + LPBM_CNT_W'(1);
        case (state_reg)
            LPBM_MON_OFF: begin
                cnt_next = '0;
                if (mon_en_reg) begin
                    state_next = LPBM_MON_SETTLE;
                end
            end
            LPBM_MON_SETTLE: begin
                if (settle_done) begin
                    state_next = LPBM_MON_WATCH;
                    cnt_next = '0;
                end
            end
            LPBM_MON_WATCH: begin
                if (!below) begin
                    cnt_next = '0;
                end else if (filt_done) begin
                    state_next = LPBM_MON_LOW;
                    cnt_next = '0;
                end
            end
            LPBM_MON_LOW: begin
                if (below) begin
                    cnt_next = '0;
                end else if (filt_done) begin
                    state_next = LPBM_MON_WATCH;
                    cnt_next = '0;
                end
            end
            default: begin
                state_next = LPBM_MON_OFF;
                cnt_next = '0;
            end
        endcase
        if (!mon_en_reg) begin
            state_next = LPBM_MON_OFF;
            cnt_next = '0;
        end else if (cfg_touch) begin
            state_next = LPBM_MON_SETTLE;
            cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LPBM_MON_OFF;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Monitor outputs and wake
    logic low_next;
    logic wake_next;

    assign low_next = (state_next == LPBM_MON_LOW);
    // low battery wakes a sleeping core
    assign wake_next = sleep_active && (wake_request || (low_next && wake_source_en));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_on <= 1'b0;
            low_battery <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            monitor_on <= mon_en_reg;
            low_battery <= low_next;
            wake_request <= wake_next;
        end
    end

endmodule
`default_nettype wire

// ### dv/lpbm_regs_chk.sv
// Port-level assertions for the display power and battery monitor registers
`default_nettype none
module lpbm_regs_chk
    import lpbm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // System state and controls
    input wire logic sleep_active,
    input wire logic converter_sleep_enable,
    input wire logic pump_bypass,
    input wire logic contrast_mode_group,
    input wire logic monitor_on,
    input wire logic low_battery,
    input wire logic wake_request
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    pump_copy_a: assert property (sfr_wr && sfr_addr == LPBM_ADDR_MSCF |->
        ##2 pump_bypass == $past(sfr_wdata[0], 2)) else $error("pump bypass not taken from write");
    sleep_copy_a: assert property (sfr_wr && sfr_addr == LPBM_ADDR_MSCF |->
        ##2 converter_sleep_enable == $past(sfr_wdata[1], 2)) else $error("sleep enable not taken from write");
    mode_copy_a: assert property (sfr_wr && sfr_addr == LPBM_ADDR_PWR |->
        ##2 contrast_mode_group == $past(sfr_wdata[3], 2)) else $error("mode group not taken from write");
    mon_copy_a: assert property (sfr_wr && sfr_addr == LPBM_ADDR_VBM |->
        ##2 monitor_on == $past(sfr_wdata[7], 2)) else $error("monitor enable not taken from write");
    mscf_ones_a: assert property (sfr_rd && sfr_addr == LPBM_ADDR_MSCF |=>
        sfr_rdata[7:2] == 6'h3F) else $error("master config upper bits not ones");
    pwr_fixed_a: assert property (sfr_rd && sfr_addr == LPBM_ADDR_PWR |=>
        sfr_rdata[7:4] == 4'h0 && sfr_rdata[2:0] == 3'h1) else $error("power fixed bits wrong");
    vbm_unused_a: assert property (sfr_rd && sfr_addr == LPBM_ADDR_VBM |=>
        !sfr_rdata[5]) else $error("monitor unused bit reads one");
    rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved without read");
    mon_off_a: assert property ($fell(monitor_on) |-> ##[0:2] !low_battery)
        else $error("low battery kept with monitor off");
    wake_drop_a: assert property (!sleep_active |=> !wake_request) else $error("wake held out of sleep");
endmodule
bind lpbm_regs lpbm_regs_chk chk_u (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sleep_active(sleep_active), .converter_sleep_enable(converter_sleep_enable),
    .pump_bypass(pump_bypass), .contrast_mode_group(contrast_mode_group), .monitor_on(monitor_on),
    .low_battery(low_battery), .wake_request(wake_request));
`default_nettype wire

// ### dv/lpbm_regs_tb.sv
// Self-checking bench for the display power and battery monitor registers
`default_nettype none
module lpbm_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lpbm_pkg::*;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic sleep_active = 1'b0;
    logic wake_source_en = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [4:0] contrast_level = 5'h03;
    logic [5:0] vbat_code = 6'h3F;
    logic [7:0] sfr_rdata;
    logic converter_run, converter_sleep_enable, pump_bypass, contrast_mode_group;
    logic monitor_on, low_battery, wake_request;
    logic [5:0] monitor_threshold;
    int failures = 0;
    int tests_run = 0;

    always #2 core_clk = ~core_clk;

    lpbm_regs dut_u (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sleep_active(sleep_active),
        .wake_source_en(wake_source_en), .contrast_level(contrast_level), .vbat_code(vbat_code),
        .converter_run(converter_run), .converter_sleep_enable(converter_sleep_enable),
        .pump_bypass(pump_bypass), .contrast_mode_group(contrast_mode_group), .monitor_on(monitor_on),
        .monitor_threshold(monitor_threshold), .low_battery(low_battery), .wake_request(wake_request));

    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        // Output copies land one edge after the register
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        check(sfr_rdata, exp);
    endtask

    // Bounded wait for the filtered low flag; settle plus filter fit well inside 400
    task automatic wait_low(input logic lvl);
        int n;
        n = 0;
        while (low_battery !== lvl && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        check({7'h00, low_battery}, {7'h00, lvl});
        if (low_battery !== lvl) close_out();
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check({4'h0, pump_bypass, converter_sleep_enable, contrast_mode_group, monitor_on}, 8'h06);
        rd(LPBM_ADDR_MSCF, 8'hFE);
        rd(LPBM_ADDR_PWR, 8'h09);
        rd(LPBM_ADDR_VBM, 8'h00);
        rd(8'hA5, LPBM_RD_NONE);
        $display("test reset values done");

        wr(LPBM_ADDR_MSCF, 8'hFD);
        check({6'h00, converter_sleep_enable, pump_bypass}, 8'h01);
        rd(LPBM_ADDR_MSCF, 8'hFD);
        @(posedge core_clk);
        sleep_active <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check({7'h00, converter_run}, 8'h00);
        wr(LPBM_ADDR_MSCF, 8'hFE);
        @(posedge core_clk);
        #1;
        check({6'h00, converter_run, pump_bypass}, 8'h02);
        @(posedge core_clk);
        sleep_active <= 1'b0;
        $display("test master config done");

        wr(LPBM_ADDR_PWR, 8'hF1);
        check({7'h00, contrast_mode_group}, 8'h00);
        rd(LPBM_ADDR_PWR, 8'h01);
        wr(LPBM_ADDR_PWR, 8'hF9);
        check({7'h00, contrast_mode_group}, 8'h01);
        rd(LPBM_ADDR_PWR, 8'h09);
        $display("test power select done");

        wr(LPBM_ADDR_VBM, 8'h7F);
        check({2'h0, monitor_threshold}, 8'h22);
        check({7'h00, monitor_on}, 8'h00);
        rd(LPBM_ADDR_VBM, 8'h5F);
        wr(LPBM_ADDR_VBM, 8'h40);
        check({2'h0, monitor_threshold}, 8'h03);
        wr(LPBM_ADDR_VBM, 8'h85);
        check({2'h0, monitor_threshold}, 8'h05);
        check({7'h00, monitor_on}, 8'h01);
        @(posedge core_clk);
        vbat_code <= 6'h04;
        sleep_active <= 1'b1;
        wake_source_en <= 1'b1;
        repeat (200) @(posedge core_clk);
        #1;
        check({7'h00, low_battery}, 8'h00);
        wait_low(1'b1);
        check({7'h00, wake_request}, 8'h01);
        @(posedge core_clk);
        sleep_active <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({7'h00, wake_request}, 8'h00);
        @(posedge core_clk);
        vbat_code <= 6'h05;
        wait_low(1'b0);
        $display("test absolute threshold done");

        wr(LPBM_ADDR_VBM, 8'hC2);
        check({2'h0, monitor_threshold}, 8'h05);
        @(posedge core_clk);
        vbat_code <= 6'h04;
        sleep_active <= 1'b1;
        wake_source_en <= 1'b0;
        wait_low(1'b1);
        check({7'h00, wake_request}, 8'h00);
        @(posedge core_clk);
        sleep_active <= 1'b0;
        wr(LPBM_ADDR_VBM, 8'h00);
        check({6'h00, monitor_on, low_battery}, 8'h00);
        $display("test linked threshold done");
        close_out();
    end
endmodule
`default_nettype wire
